// file: cdpm_ctrl.sv
// clock divider, bus master clock select, subclock filter and mode control
//
// Function
// - divide system clock into phi/2, /4, /8, /16 and /32
// - three-bit select picks bus master clock, full rate or divided
// - code 000 full rate, 001..101 divide by 2..32, 11X prohibited
// - subclock input filtered by sampling with divided system clock
// - noise filter rate select chooses the sampling rate
// - no sampling in subactive, subsleep or watch; input passes raw
// - eight operating modes; all but high speed are power down
// - sleep modes hit cpu, medium cpu+bus, subactive adds peripherals
// - module stop may combine with high or medium speed
// - reset gives high speed, all peripherals but transfer ctrl stopped
// - cpu and each peripheral can be stopped separately
// - system osc runs high/medium/sleep; subclock osc halts only in standby
// - cpu halts retained, runs on subclock in subactive; irqs except hw standby
// - ram retained in every mode including both standby modes
// - standby pin low forces hw standby; reset pin low forces reset except in hw standby
`timescale 1ns/100ps
module cdpm_ctrl (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // external pins
  input  wire logic                      reset_pin_n,
  input  wire logic                      hw_standby_pin_n,
  input  wire logic                      subclock_in_pin,
  // control bits
  input  wire logic [2:0]                clk_sel,
  input  wire logic                      noise_filter_rate_sel,
  input  wire cdpm_pkg::cdpm_mode_t      mode_req,
  input  wire logic                      mode_req_valid,
  input  wire logic [cdpm_pkg::NUM_PERIPH-1:0] mstop_wr_data,
  input  wire logic                      mstop_wr,
  input  wire logic [cdpm_pkg::NUM_PERIPH-1:0] stop_reset_type,
  // clock outputs
  output logic [cdpm_pkg::DIV_W-1:0]     med_clk,
  output logic                           bus_clk,
  output logic                           bus_clk_en,
  output logic                           subclk_filt,
  // status outputs
  output cdpm_pkg::cdpm_mode_t           mode,
  output cdpm_pkg::cdpm_status_t         status,
  output cdpm_pkg::cdpm_periph_t         periph,
  output logic                           cpu_reset
);

  // ==========================================================
  // free-running divider
  logic [cdpm_pkg::DIV_W-1:0] div_r, div_nxt;

  // counter bit k toggles at phi/2^(k+1)
  always_comb begin
    div_nxt = div_r + cdpm_pkg::DIV_ONE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= cdpm_pkg::DIV_ZERO;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ==========================================================
  // bus master clock select
  // decoding of the select field, used for the pending choice in clk_sel only
  function automatic logic sel_legal(input logic [2:0] s);
    sel_legal = (s <= cdpm_pkg::SEL_DIV32);
  endfunction : sel_legal

  // low divider bits that are all one in the last cycle of a selected period;
  // a mask instead of a part-select, since the select is not a constant
  function automatic logic [cdpm_pkg::DIV_W-1:0] period_mask(input logic [2:0] s);
    period_mask = '0;
    for (int k = 0; k < cdpm_pkg::DIV_W; k++) begin
      if (k < int'(s)) begin
        period_mask[k] = 1'b1;
      end
    end
  endfunction : period_mask

  logic [2:0]                 sel_r, sel_nxt;
  logic                       bus_clk_r, bus_clk_nxt;
  logic                       bus_en_r, bus_en_nxt;
  logic [cdpm_pkg::DIV_W-1:0] med_r, med_nxt;
  logic                       tap_rise;

  // switch only when the whole divider wraps, so every phase is whole;
  // prohibited codes are ignored and the old choice stays
  always_comb begin
    tap_rise = (div_nxt == cdpm_pkg::DIV_ZERO);
    sel_nxt  = sel_r;
    if (tap_rise && sel_legal(clk_sel)) begin
      sel_nxt = clk_sel;
    end
    med_nxt = div_nxt;
    if (sel_r == cdpm_pkg::SEL_HIGH) begin
      bus_clk_nxt = ~bus_clk_r;
      bus_en_nxt  = 1'b1;
    end else begin
      bus_clk_nxt = div_nxt[sel_r - cdpm_pkg::SEL_DIV2];
      bus_en_nxt  = ((div_r & period_mask(sel_r)) == period_mask(sel_r)) ? 1'b1 : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_r     <= cdpm_pkg::SEL_HIGH;
      bus_clk_r <= 1'b0;
      bus_en_r  <= 1'b0;
      med_r     <= cdpm_pkg::DIV_ZERO;
    end else begin
      sel_r     <= sel_nxt;
      bus_clk_r <= bus_clk_nxt;
      bus_en_r  <= bus_en_nxt;
      med_r     <= med_nxt;
    end
  end

  // ==========================================================
  // operating mode
  cdpm_pkg::cdpm_mode_t       mode_r, mode_nxt;
  logic [cdpm_pkg::NUM_PERIPH-1:0] mstop_r, mstop_nxt;
  logic                       cpu_rst_r, cpu_rst_nxt;

  // standby pin wins over everything, reset pin over all but hw standby
  always_comb begin
    mode_nxt    = mode_r;
    mstop_nxt   = mstop_r;
    cpu_rst_nxt = 1'b0;
    if (mode_req_valid) begin
      mode_nxt = mode_req;
    end
    if (mstop_wr) begin
      mstop_nxt = mstop_wr_data;
    end
    if (!reset_pin_n && mode_r != cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N) begin
      mode_nxt    = cdpm_pkg::CDPM_HIGH;
      mstop_nxt   = cdpm_pkg::MSTOP_RST;
      cpu_rst_nxt = 1'b1;
    end
    if (!hw_standby_pin_n) begin
      mode_nxt    = cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N;
      mstop_nxt   = cdpm_pkg::MSTOP_RST;
      cpu_rst_nxt = 1'b1;
    end else if (mode_r == cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N && reset_pin_n) begin
      mode_nxt    = cdpm_pkg::CDPM_HIGH;  // leave standby through reset
      cpu_rst_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r    <= cdpm_pkg::CDPM_HIGH;
      mstop_r   <= cdpm_pkg::MSTOP_RST;
      cpu_rst_r <= 1'b1;
    end else begin
      mode_r    <= mode_nxt;
      mstop_r   <= mstop_nxt;
      cpu_rst_r <= cpu_rst_nxt;
    end
  end

  // ==========================================================
  // per-mode enables and peripheral indications
  cdpm_pkg::cdpm_status_t stat_r, stat_nxt;
  cdpm_pkg::cdpm_periph_t per_r, per_nxt;
  logic                   mode_halts_per;
  logic                   mode_resets_per;

  always_comb begin
    stat_nxt.sys_osc_run = (mode_nxt == cdpm_pkg::CDPM_HIGH) ||
                           (mode_nxt == cdpm_pkg::CDPM_MEDIUM) ||
                           (mode_nxt == cdpm_pkg::CDPM_SLEEP);
    stat_nxt.sub_osc_run = (mode_nxt != cdpm_pkg::CDPM_SW_HW_STANDBY_PIN_N) &&
                           (mode_nxt != cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N);
    stat_nxt.cpu_run     = (mode_nxt == cdpm_pkg::CDPM_HIGH) ||
                           (mode_nxt == cdpm_pkg::CDPM_MEDIUM) ||
                           (mode_nxt == cdpm_pkg::CDPM_SUBACT);
    stat_nxt.cpu_on_sub  = (mode_nxt == cdpm_pkg::CDPM_SUBACT);
    stat_nxt.ext_irq_en  = (mode_nxt != cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N);
    stat_nxt.ram_retain  = 1'b1;
    stat_nxt.io_hiz      = (mode_nxt == cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N);
    stat_nxt.power_down  = (mode_nxt != cdpm_pkg::CDPM_HIGH) ||
                           (mstop_nxt != '0);
    // sleep mode touches only the cpu; subactive, subsleep, watch and both standbys halt peripherals
    mode_halts_per  = (mode_nxt == cdpm_pkg::CDPM_SUBACT) ||
                      (mode_nxt == cdpm_pkg::CDPM_WATCH) ||
                      (mode_nxt == cdpm_pkg::CDPM_SUBSLEEP) ||
                      (mode_nxt == cdpm_pkg::CDPM_SW_HW_STANDBY_PIN_N) ||
                      (mode_nxt == cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N);
    mode_resets_per = (mode_nxt == cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N);
    per_nxt.halt = mstop_nxt | {cdpm_pkg::NUM_PERIPH{mode_halts_per}};
    per_nxt.rst  = ({cdpm_pkg::NUM_PERIPH{mode_resets_per}}) |
                   (per_nxt.halt & stop_reset_type);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_r <= '0;
      per_r  <= '0;
    end else begin
      stat_r <= stat_nxt;
      per_r  <= per_nxt;
    end
  end

  // ==========================================================
  // subclock noise filter
  logic [1:0] nf_hist_r, nf_hist_nxt;
  logic       sub_r, sub_nxt;
  logic       samp_now;
  logic       bypass;

  // sampling on a divider tap; a pulse shorter than the sample gap is lost,
  // the price of the filter
  always_comb begin
    samp_now = noise_filter_rate_sel ?
               (div_r[cdpm_pkg::NF_SLOW_TAP:0] == '1) :
               (div_r[cdpm_pkg::NF_FAST_TAP:0] == '1);
    bypass   = (mode_r == cdpm_pkg::CDPM_SUBACT) ||
               (mode_r == cdpm_pkg::CDPM_SUBSLEEP) ||
               (mode_r == cdpm_pkg::CDPM_WATCH);
    nf_hist_nxt = nf_hist_r;
    sub_nxt     = sub_r;
    if (bypass) begin
      sub_nxt = subclock_in_pin;
    end else if (samp_now) begin
      nf_hist_nxt = {nf_hist_r[0], subclock_in_pin};
      if (nf_hist_nxt == cdpm_pkg::NF_AGREE) begin
        sub_nxt = 1'b1;
      end else if (nf_hist_nxt == 2'h0) begin
        sub_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nf_hist_r <= 2'h0;
      sub_r     <= 1'b0;
    end else begin
      nf_hist_r <= nf_hist_nxt;
      sub_r     <= sub_nxt;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  assign med_clk     = med_r;
  assign bus_clk     = bus_clk_r;
  assign bus_clk_en  = bus_en_r;
  assign subclk_filt = sub_r;
  assign mode        = mode_r;
  assign status      = stat_r;
  assign periph      = per_r;
  assign cpu_reset   = cpu_rst_r;

endmodule : cdpm_ctrl

// file: cdpm_pkg.sv
// package: constants, modes and carrier structs for the clock divider / power mode control
package cdpm_pkg;

  // ==========================================================
  // clock select codes
  localparam logic [2:0] SEL_HIGH  = 3'h0;
  localparam logic [2:0] SEL_DIV2  = 3'h1;
  localparam logic [2:0] SEL_DIV32 = 3'h5;

  // ==========================================================
  // divider and filter sizing
  localparam int          DIV_W       = 5;
  localparam logic [4:0]  DIV_ONE     = 5'h01;
  localparam logic [4:0]  DIV_ZERO    = 5'h00;
  localparam logic [3:0]  NF_FAST_TAP = 4'h0;   // sample tap index, phi/2
  localparam logic [3:0]  NF_SLOW_TAP = 4'h3;   // sample tap index, phi/16
  localparam logic [1:0]  NF_AGREE    = 2'h3;   // history pattern when both samples agree high
  localparam int          NUM_PERIPH  = 8;
  localparam int          DTC_IDX     = 0;      // slot of the data transfer ctrl
  localparam logic [7:0]  MSTOP_RST   = 8'hFE;  // all stopped but the transfer ctrl

  // ==========================================================
  // operating modes (module stop is orthogonal, see periph stop vector)
  typedef enum logic [2:0] {
    CDPM_HIGH, CDPM_MEDIUM, CDPM_SUBACT, CDPM_SLEEP,
    CDPM_SUBSLEEP, CDPM_WATCH, CDPM_SW_HW_STANDBY_PIN_N, CDPM_HW_HW_STANDBY_PIN_N
  } cdpm_mode_t;

  // block enables derived from the mode
  typedef struct packed {
    logic sys_osc_run;
    logic sub_osc_run;
    logic cpu_run;
    logic cpu_on_sub;
    logic ext_irq_en;
    logic ram_retain;
    logic io_hiz;
    logic power_down;
  } cdpm_status_t;

  // per-peripheral indication
  typedef struct packed {
    logic [NUM_PERIPH-1:0] halt;
    logic [NUM_PERIPH-1:0] rst;
  } cdpm_periph_t;

endpackage : cdpm_pkg

// file: cdpm_checker.sv
// checker: port assertions for the clock divider and mode control
`timescale 1ns/100ps
module cdpm_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and requests
  input wire logic reset_pin_n,
  input wire logic hw_standby_pin_n,
  input wire logic subclock_in_pin,
  input wire logic mode_req_valid,
  input wire cdpm_pkg::cdpm_mode_t mode_req,
  // watched outputs
  input wire logic [cdpm_pkg::DIV_W-1:0] med_clk,
  input wire logic bus_clk_en,
  input wire logic subclk_filt,
  input wire cdpm_pkg::cdpm_mode_t mode,
  input wire cdpm_pkg::cdpm_status_t status,
  input wire logic cpu_reset
);
  // ==========================================================
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire hw = mode == cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N;
  wire high = mode == cdpm_pkg::CDPM_HIGH;
  wire run = high || mode == cdpm_pkg::CDPM_MEDIUM;
  wire sub = mode inside {cdpm_pkg::CDPM_SUBACT, cdpm_pkg::CDPM_SUBSLEEP, cdpm_pkg::CDPM_WATCH};
  logic [1:0] up_r;
  logic [5:0] gap_r, gap_nxt;
  // gap idles outside run modes, where the bus clock may rightly stop
  always_comb gap_nxt = (bus_clk_en || !run) ? 6'h00 : gap_r + 6'h01;
  // status is zero for one edge after reset, so wait two
  always_ff @(posedge clk) begin
    gap_r <= rst ? 6'h00 : gap_nxt;
    up_r <= rst ? 2'h0 : {up_r[0], 1'b1};
  end
  sequence s_quarter;
    ##2 $fell(med_clk[1]) ##2 $rose(med_clk[1]);
  endsequence
  // ==========================================================
  // assertions
  AST_DIV4: assert property ($rose(med_clk[1]) |-> s_quarter)
    else $error("quarter rate tap has wrong period");
  AST_BUS_GAP: assert property (gap_r < 6'h22)
    else $error("bus clock enable missing too long");
  AST_HW_HW_STANDBY_PIN_N: assert property (!hw_standby_pin_n |=> hw)
    else $error("standby pin ignored");
  AST_RESET_PIN: assert property (hw_standby_pin_n && !reset_pin_n && !hw
    |=> high && cpu_reset) else $error("reset pin ignored");
  AST_MODE_REQ: assert property (mode_req_valid && reset_pin_n && hw_standby_pin_n && !hw
    |=> mode == $past(mode_req)) else $error("mode request not taken");
  AST_CLOCK_GEN: assert property (up_r[1] |-> status.ext_irq_en == !hw &&
    status.sys_osc_run == (run || mode == cdpm_pkg::CDPM_SLEEP)) else $error("bad enables");
  AST_BYPASS: assert property (sub && $past(sub)
    |-> subclk_filt == $past(subclock_in_pin)) else $error("subclock not passed raw");
  AST_RESET_HIGH: assert property ($fell(rst) |-> high && cpu_reset)
    else $error("reset did not give high speed");
endmodule : cdpm_checker

// file: cdpm_bus_master_model.sv
// partner model: bus master side timing the bus clock enable
`timescale 1ns/100ps
module cdpm_bus_master_model (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // clock and enable from the bus clock selector
  input  wire logic  bus_clk,
  input  wire logic  bus_clk_en,
  // cycles between the last two enables, cycles of the last high phase
  output logic [7:0] period,
  output logic [7:0] hi_len
);
  logic [7:0] cnt_r;
  logic [7:0] hi_r;
  // high phase length; only the last whole phase is kept
  always_ff @(posedge clk) begin
    hi_r <= (rst || !bus_clk) ? 8'h00 : hi_r + 8'h01;
    if (!bus_clk && hi_r != 8'h00) begin
      hi_len <= hi_r;
    end
  end
  // period only moves on an enable, so a stopped clock shows stale
  always_ff @(posedge clk) begin
    cnt_r <= (rst || bus_clk_en) ? 8'h01 : cnt_r + 8'h01;
    if (bus_clk_en && !rst) begin
      period <= cnt_r;
    end
  end
endmodule : cdpm_bus_master_model

// file: cdpm_tb.sv
// testbench: random and corner checks of the clock and power mode control
`timescale 1ns/100ps
module testbench;
  // ==========================================================
  // design connections
  logic clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1, hw_standby_pin_n = 1'b1;
  logic subclock_in_pin = 1'b0, noise_filter_rate_sel = 1'b0;
  logic mode_req_valid = 1'b0, mstop_wr = 1'b0;
  logic [2:0] clk_sel = 3'h0;
  logic [7:0] mstop_wr_data = 8'h00, stop_reset_type = 8'h00, period, hi_len, d;
  cdpm_pkg::cdpm_mode_t mode_req = cdpm_pkg::CDPM_HIGH, mode;
  cdpm_pkg::cdpm_mode_t m_i;
  cdpm_pkg::cdpm_status_t status;
  cdpm_pkg::cdpm_periph_t periph;
  logic [4:0] med_clk;
  logic bus_clk, bus_clk_en, subclk_filt, cpu_reset;
  int miscompares = 0, n_checks = 0, cycles = 0;
  // 50 MHz system clock
  always #10 clk = ~clk;
  cdpm_ctrl u_dut (
    .clk                   (clk),
    .rst                   (rst),
    .reset_pin_n           (reset_pin_n),
    .hw_standby_pin_n      (hw_standby_pin_n),
    .subclock_in_pin       (subclock_in_pin),
    .clk_sel               (clk_sel),
    .noise_filter_rate_sel (noise_filter_rate_sel),
    .mode_req              (mode_req),
    .mode_req_valid        (mode_req_valid),
    .mstop_wr_data         (mstop_wr_data),
    .mstop_wr              (mstop_wr),
    .stop_reset_type       (stop_reset_type),
    .med_clk               (med_clk),
    .bus_clk               (bus_clk),
    .bus_clk_en            (bus_clk_en),
    .subclk_filt           (subclk_filt),
    .mode                  (mode),
    .status                (status),
    .periph                (periph),
    .cpu_reset             (cpu_reset)
  );
  cdpm_bus_master_model u_bm (
    .clk        (clk),
    .rst        (rst),
    .bus_clk    (bus_clk),
    .bus_clk_en (bus_clk_en),
    .period     (period),
    .hi_len     (hi_len)
  );
  // ==========================================================
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic req(input cdpm_pkg::cdpm_mode_t m);
    mode_req = m;
    mode_req_valid = 1'b1;
    step(1);
    mode_req_valid = 1'b0;
  endtask : req
  // expected {sys osc, sub osc, cpu run, cpu on subclock}
  function automatic logic [3:0] exp_st(input cdpm_pkg::cdpm_mode_t m);
    exp_st[3] = m inside {cdpm_pkg::CDPM_HIGH, cdpm_pkg::CDPM_MEDIUM, cdpm_pkg::CDPM_SLEEP};
    exp_st[2] = !(m inside {cdpm_pkg::CDPM_SW_HW_STANDBY_PIN_N, cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N});
    exp_st[1] = m inside {cdpm_pkg::CDPM_HIGH, cdpm_pkg::CDPM_MEDIUM, cdpm_pkg::CDPM_SUBACT};
    exp_st[0] = m == cdpm_pkg::CDPM_SUBACT;
  endfunction : exp_st
  // expected {irq enable, ram retain, pins released, power down}
  function automatic logic [3:0] exp_lo(input cdpm_pkg::cdpm_mode_t m, input logic [7:0] ms);
    exp_lo[3] = m != cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N;
    exp_lo[2] = 1'b1;
    exp_lo[1] = m == cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N;
    exp_lo[0] = m != cdpm_pkg::CDPM_HIGH || ms != 8'h00;
  endfunction : exp_lo
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // hang guard, far above the thousand or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      test_done();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    d = 8'($urandom(32'h1EEA9682));
    stop_reset_type = 8'($urandom);
    step(3);
    rst = 1'b0;
    step(2);
    check(periph.halt, cdpm_pkg::MSTOP_RST);
    for (int i = 0; i < 7; i++) begin
      m_i = cdpm_pkg::cdpm_mode_t'(i);
      req(m_i);
      check(8'(mode), 8'(i));
      check(8'(status[7:4]), 8'(exp_st(cdpm_pkg::cdpm_mode_t'(i))));
      check(8'(status[3:0]), 8'(exp_lo(m_i, cdpm_pkg::MSTOP_RST)));
      repeat (4) begin
        subclock_in_pin = 1'($urandom);
        step(1);
      end
    end
    req(cdpm_pkg::CDPM_HIGH);
    // strobe held across back-to-back writes
    mstop_wr = 1'b1;
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 8'h00 : 8'($urandom);  // corner: nothing stopped
      mstop_wr_data = d;
      step(1);
      check(periph.halt, d);
      check(periph.rst, d & stop_reset_type);
      check(8'(status[3:0]), 8'(exp_lo(cdpm_pkg::CDPM_HIGH, d)));
    end
    mstop_wr = 1'b0;
    req(cdpm_pkg::CDPM_MEDIUM);
    check(periph.halt, d);
    step(1);
    req(cdpm_pkg::CDPM_SLEEP);
    reset_pin_n = 1'b0;
    step(1);
    check(8'(mode), 8'(cdpm_pkg::CDPM_HIGH));
    check(8'(cpu_reset), 8'h01);
    reset_pin_n = 1'b1;
    step(2);
    check(periph.halt, cdpm_pkg::MSTOP_RST);
    hw_standby_pin_n = 1'b0;
    step(2);
    check(8'(mode), 8'(cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N));
    check(8'(status[7:4]), 8'(exp_st(cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N)));
    check(8'(status[3:0]), 8'(exp_lo(cdpm_pkg::CDPM_HW_HW_STANDBY_PIN_N, cdpm_pkg::MSTOP_RST)));
    hw_standby_pin_n = 1'b1;
    step(3);
    check(8'(mode), 8'(cdpm_pkg::CDPM_HIGH));
    for (int s = 0; s < 8; s++) begin
      clk_sel = 3'(s);
      step(100);
      check(period, s < 6 ? 8'h01 << s : 8'h20);
      check(hi_len, s == 0 ? 8'h01 : s < 6 ? 8'h01 << (s - 1) : 8'h10);
    end
    for (int r = 0; r < 2; r++) begin
      noise_filter_rate_sel = 1'(r);
      subclock_in_pin = 1'b1;
      step(1);
      subclock_in_pin = 1'b0;
      step(40);
      check(8'(subclk_filt), 8'h00);
      subclock_in_pin = 1'b1;
      step(8);
      check(8'(subclk_filt), 8'(r == 0));
      step(40);
      check(8'(subclk_filt), 8'h01);
    end
    test_done();
  end
endmodule : testbench
bind cdpm_ctrl cdpm_checker u_chk (
  .clk              (clk),
  .rst              (rst),
  .reset_pin_n      (reset_pin_n),
  .hw_standby_pin_n (hw_standby_pin_n),
  .subclock_in_pin  (subclock_in_pin),
  .mode_req_valid   (mode_req_valid),
  .mode_req         (mode_req),
  .med_clk          (med_clk),
  .bus_clk_en       (bus_clk_en),
  .subclk_filt      (subclk_filt),
  .mode             (mode),
  .status           (status),
  .cpu_reset        (cpu_reset)
);
